// ==== rtl/iptmr_cfg.svh ====
`ifndef IPTMR_CFG_SVH
`define IPTMR_CFG_SVH

// Register addresses on the byte write/read port.
`define IPTMR_ADDR_PORT1_DIR  16'hFF21
`define IPTMR_ADDR_MODE       16'hFF69
`define IPTMR_ADDR_PERIOD     16'hFF6A
`define IPTMR_ADDR_DUTY       16'hFF6B

// Reset values.
`define IPTMR_RST_PORT1_DIR   8'hFF
`define IPTMR_RST_MODE        8'h00
`define IPTMR_RST_CMP         8'h00

// Mode register field positions.
`define IPTMR_BIT_EN          7
`define IPTMR_BIT_CKS_HI      6
`define IPTMR_BIT_CKS_LO      4
`define IPTMR_BIT_MD_HI       3
`define IPTMR_BIT_MD_LO       2
`define IPTMR_BIT_LEV         1
`define IPTMR_BIT_OEN         0

// Timer output pin position in port 1.
`define IPTMR_PIN_TIMER       5

// Count clocks a new duty value must age before it may be transferred.
`define IPTMR_DUTY_AGE        2'h3

`endif

// ==== rtl/iptmr_pkg.sv ====
package iptmr_pkg;

  typedef enum logic [1:0] {
    IPTMR_MD_INTERVAL = 2'b00,
    IPTMR_MD_PWM      = 2'b10
  } iptmr_mode_e;

  typedef enum logic {
    IPTMR_SEL_PERIOD = 1'b0,
    IPTMR_SEL_DUTY   = 1'b1
  } iptmr_sel_e;

  typedef struct packed {
    logic        en;
    logic [2:0]  cks;
    logic [1:0]  md;
    logic        lev;
    logic        oen;
  } iptmr_mode_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } iptmr_acc_s;

endpackage

// ==== rtl/iptmr_top.sv ====
`include "iptmr_cfg.svh"

module iptmr_top
  import iptmr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire iptmr_acc_s i_acc,
  output logic [7:0]      o_rd_data,
  output logic [7:0]      o_port1_dir,
  output logic            o_timer_out,
  output logic            o_timer_pin_o,
  output logic            o_timer_pin_oe_n,
  output logic            o_match_irq
);

  iptmr_mode_s mode_q;
  iptmr_sel_e  sel_q;
  logic [7:0]  port1_dir_q;
  logic [7:0]  period_q;
  logic [7:0]  duty_act_q;
  logic [7:0]  duty_buf_q;
  logic        duty_pend_q;
  logic [1:0]  duty_age_q;
  logic [9:0]  pre_q;
  logic [7:0]  cnt_q;
  logic        run_q;
  logic        out_q;
  logic        irq_q;
  logic [7:0]  rd_q;
  logic        tick;
  logic        pwm;
  logic        duty_hit;
  logic        xfer;

  function automatic logic wr_at(input iptmr_acc_s a, input logic [15:0] ad);
    wr_at = a.wr && (a.addr == ad);
  endfunction

  // Count clock divider; unlisted selections never tick.
  always_comb
  begin
    case (mode_q.cks)
      3'h0: tick = 1'b1;
      3'h1: tick = pre_q[0];
      3'h2: tick = &pre_q[1:0];
      3'h3: tick = &pre_q[5:0];
      3'h4: tick = &pre_q;
      default: tick = 1'b0;
    endcase
  end

  // Divider restarts on stop so the first count clock is predictable.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !mode_q.en)
      pre_q <= 10'h000;
    else
      pre_q <= pre_q + 10'h001;
  end

  assign pwm      = (mode_q.md == IPTMR_MD_PWM);
  assign duty_hit = pwm && (sel_q == IPTMR_SEL_DUTY) && (cnt_q == duty_act_q);
  assign xfer     = duty_hit && duty_pend_q && (duty_age_q == `IPTMR_DUTY_AGE);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      port1_dir_q <= `IPTMR_RST_PORT1_DIR;
    else if (wr_at(i_acc, `IPTMR_ADDR_PORT1_DIR))
      port1_dir_q <= i_acc.wdata;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      mode_q   <= `IPTMR_RST_MODE;
      period_q <= `IPTMR_RST_CMP;
    end
    else
    begin
      if (wr_at(i_acc, `IPTMR_ADDR_MODE))
        mode_q <= i_acc.wdata;
      if (wr_at(i_acc, `IPTMR_ADDR_PERIOD))
        period_q <= i_acc.wdata;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      duty_act_q  <= `IPTMR_RST_CMP;
      duty_buf_q  <= `IPTMR_RST_CMP;
      duty_pend_q <= 1'b0;
      duty_age_q  <= 2'h0;
    end
    else if (wr_at(i_acc, `IPTMR_ADDR_DUTY))
    begin
      duty_buf_q  <= i_acc.wdata;
      duty_pend_q <= mode_q.en;
      duty_age_q  <= 2'h0;
      // While stopped the value takes effect at once.
      if (!mode_q.en)
        duty_act_q <= i_acc.wdata;
    end
    else if (tick && mode_q.en)
    begin
      if (xfer)
      begin
        duty_act_q  <= duty_buf_q;
        duty_pend_q <= 1'b0;
      end
      if (duty_age_q != `IPTMR_DUTY_AGE)
        duty_age_q <= duty_age_q + 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !mode_q.en)
    begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      out_q <= 1'b0;
      irq_q <= 1'b0;
      sel_q <= IPTMR_SEL_PERIOD;
    end
    else if (tick)
    begin
      run_q <= 1'b1;
      irq_q <= 1'b0;
      if (!run_q && pwm)
        cnt_q <= 8'h00;
      else if (!pwm)
      begin
        if (cnt_q == period_q)
        begin
          cnt_q <= 8'h00;
          irq_q <= 1'b1;
          out_q <= ~out_q;
        end
        else
          cnt_q <= cnt_q + 8'h01;
      end
      else
      begin
        case (sel_q)
          IPTMR_SEL_PERIOD:
          begin
            if (cnt_q == period_q)
            begin
              cnt_q <= 8'h00;
              irq_q <= 1'b1;
              out_q <= 1'b1;
              sel_q <= IPTMR_SEL_DUTY;
            end
            else
              cnt_q <= cnt_q + 8'h01;
          end
          default:
          begin
            if (duty_hit)
            begin
              out_q <= 1'b0;
              sel_q <= IPTMR_SEL_PERIOD;
            end
            cnt_q <= cnt_q + 8'h01;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      rd_q <= 8'h00;
    else if (i_acc.rd)
    begin
      if (i_acc.addr == `IPTMR_ADDR_PORT1_DIR)
        rd_q <= port1_dir_q;
      else if (i_acc.addr == `IPTMR_ADDR_MODE)
        rd_q <= mode_q;
      else if (i_acc.addr == `IPTMR_ADDR_PERIOD)
        rd_q <= period_q;
      else if (i_acc.addr == `IPTMR_ADDR_DUTY)
        rd_q <= duty_act_q;
      else
        rd_q <= 8'h00;
    end
  end

  // interval square wave or pwm waveform when oen is set; default level otherwise
  // Inactive level is the default level; active is its inverse.
  assign o_timer_out      = mode_q.oen ? (out_q ^ mode_q.lev) : mode_q.lev;
  assign o_timer_pin_o    = o_timer_out;
  assign o_timer_pin_oe_n = port1_dir_q[`IPTMR_PIN_TIMER];
  assign o_port1_dir      = port1_dir_q;
  assign o_match_irq      = irq_q;
  assign o_rd_data        = rd_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_irq_interval: assert property (
    mode_q.en && tick && run_q && !pwm && cnt_q == period_q
    |=> irq_q && cnt_q == 8'h00)
    else $error("interval match did not clear and interrupt");
  a_toggle_on_match: assert property (
    mode_q.en && tick && !pwm && cnt_q == period_q
    |=> out_q != $past(out_q))
    else $error("interval match did not invert output");
  a_no_duty_interval: assert property (
    mode_q.en && !pwm |-> sel_q == IPTMR_SEL_PERIOD)
    else $error("duty compare used in interval mode");
  a_stop_inactive: assert property (
    !mode_q.en |=> !irq_q && !out_q && cnt_q == 8'h00)
    else $error("stop did not force inactive");
  a_pwm_period: assert property (
    mode_q.en && tick && run_q && pwm && sel_q == IPTMR_SEL_PERIOD
    && cnt_q == period_q
    |=> out_q && irq_q && sel_q == IPTMR_SEL_DUTY && cnt_q == 8'h00)
    else $error("pwm period match wrong");
  a_pwm_duty: assert property (
    mode_q.en && tick && run_q && duty_hit
    |=> !out_q && !irq_q && sel_q == IPTMR_SEL_PERIOD
    && cnt_q == $past(cnt_q) + 8'h01)
    else $error("pwm duty match wrong");
  a_pwm_skip: assert property (
    mode_q.en && tick && !run_q && pwm |=> cnt_q == 8'h00 && !out_q)
    else $error("pwm start did not mask a count clock");
  a_duty_young: assert property (
    mode_q.en && tick && duty_hit && duty_age_q != `IPTMR_DUTY_AGE
    && !wr_at(i_acc, `IPTMR_ADDR_DUTY)
    |=> duty_act_q == $past(duty_act_q))
    else $error("young duty value transferred");
  a_duty_xfer: assert property (
    mode_q.en && tick && xfer && !wr_at(i_acc, `IPTMR_ADDR_DUTY)
    |=> duty_act_q == $past(duty_buf_q) && !duty_pend_q)
    else $error("buffered duty not transferred");
  a_irq_width: assert property (
    $rose(irq_q) |-> irq_q until_with (tick || !mode_q.en))
    else $error("interrupt shorter than one count clock");
  a_dir_reset: assert property (
    @(posedge i_sys_clk) disable iff (1'b0)
    !i_rst_n |=> port1_dir_q == `IPTMR_RST_PORT1_DIR)
    else $error("direction register reset value wrong");

  c_interval_match: cover property (mode_q.en && !pwm && irq_q);
  c_pwm_cycle: cover property (pwm && $rose(out_q) ##[1:600] $fell(out_q));
  c_duty_xfer: cover property (mode_q.en && tick && xfer);

endmodule

// ==== tb/interval_pwm_timer_bench.sv ====
`include "iptmr_cfg.svh"

module interval_pwm_timer_bench
  import iptmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       i_sys_clk;
  logic       i_rst_n;
  iptmr_acc_s acc;
  logic [7:0] rd_data;
  logic [7:0] dir;
  logic       t_out;
  logic       pin_o;
  logic       pin_oe_n;
  logic       irq;
  logic       lev;
  int         num_errors;
  int         total_checks;
  int         seed;
  int         c;
  int         hi;
  int         lo;
  int         dv;
  logic [7:0] n;
  logic [7:0] m;
  logic [7:0] m2;
  logic [2:0] sel;
  logic       oen;

  iptmr_top dut_u (
    .i_sys_clk        (i_sys_clk),
    .i_rst_n          (i_rst_n),
    .i_acc            (acc),
    .o_rd_data        (rd_data),
    .o_port1_dir      (dir),
    .o_timer_out      (t_out),
    .o_timer_pin_o    (pin_o),
    .o_timer_pin_oe_n (pin_oe_n),
    .o_match_irq      (irq)
  );

  initial
  begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic summarize;
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    acc = '{wr: w, rd: !w, addr: a, wdata: d};
    tick(1);
    acc = '0;
    // One idle edge between accesses keeps each strobe a clean pulse.
    tick(1);
  endtask

  task automatic rdchk(input string nm, input logic [15:0] a,
                       input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, rd_data});
  endtask

  // The active level is the inverse of the default level.
  function automatic logic sig(input logic w);
    return w ? irq : (t_out ^ lev);
  endfunction

  task automatic wait_for(input logic w, input logic v, output int k);
    k = 0;
    while (sig(w) !== v)
    begin
      tick(1);
      k++;
      if (k > 20000)
      begin
        chk("wait bound", 16'h0000, 16'h0001);
        summarize();
      end
    end
  endtask

  task automatic meas(input logic w, output int h, output int l);
    int k;
    wait_for(w, 1'b0, k);
    wait_for(w, 1'b1, k);
    wait_for(w, 1'b0, h);
    wait_for(w, 1'b1, l);
  endtask

  task automatic start(input logic [1:0] md);
    bus(1'b1, `IPTMR_ADDR_MODE, {1'b0, sel, md, lev, oen});
    bus(1'b1, `IPTMR_ADDR_PERIOD, n);
    bus(1'b1, `IPTMR_ADDR_DUTY, m);
    bus(1'b1, `IPTMR_ADDR_MODE, {1'b1, sel, md, lev, oen});
  endtask

  task automatic stop(input logic [1:0] md);
    bus(1'b1, `IPTMR_ADDR_MODE, {1'b0, sel, md, lev, oen});
    tick(2);
    chk("stop out", 16'(lev), 16'(t_out));
    chk("stop irq", 16'h0000, 16'(irq));
  endtask

  initial
  begin
    seed = 32'h0D110BF2;
    acc = '0;
    oen = 1'b1;
    i_rst_n = 1'b0;
    lev = 1'b0;
    tick(3);
    i_rst_n = 1'b1;
    chk("oe_n rst", 16'h0001, 16'(pin_oe_n));
    rdchk("dir rst", `IPTMR_ADDR_PORT1_DIR, 8'hFF);
    rdchk("mode rst", `IPTMR_ADDR_MODE, 8'h00);
    rdchk("period rst", `IPTMR_ADDR_PERIOD, 8'h00);
    rdchk("duty rst", `IPTMR_ADDR_DUTY, 8'h00);
    rdchk("unmapped", 16'hFF00, 8'h00);
    m = 8'($random(seed));
    bus(1'b1, `IPTMR_ADDR_PORT1_DIR, m);
    rdchk("dir rw", `IPTMR_ADDR_PORT1_DIR, m);
    chk("oe_n bit", 16'(m[5]), 16'(pin_oe_n));
    // pins five and six to output
    bus(1'b1, `IPTMR_ADDR_PORT1_DIR, m & 8'h9F);
    chk("oe_n drive", 16'h0000, 16'(pin_oe_n));
    chk("dir out", 16'(m & 8'h9F), 16'(dir));
    // Every ticking count clock selection (0 to 4); the slowest runs with a short period.
    for (int s = 0; s < 5; s++)
    begin
      sel = 3'(s);
      dv = (s < 3) ? (1 << s) : ((s == 3) ? 64 : 1024);
      n = 8'(1 + {$random(seed)} % ((s < 4) ? 12 : 2));
      m = 8'($random(seed));
      lev = 1'($random(seed));
      start(IPTMR_MD_INTERVAL);
      wait_for(1'b1, 1'b1, c);
      // The bus task's idle edge after the enable write is counted back in.
      if (s == 0)
        chk("first irq", 16'(n + 1), 16'(c + 1));
      // Duty writes while running must leave the interval untouched.
      bus(1'b1, `IPTMR_ADDR_DUTY, 8'({$random(seed)} % n));
      meas(1'b0, hi, lo);
      chk("sq high", 16'((n + 1) * dv), 16'(hi));
      chk("sq low", 16'((n + 1) * dv), 16'(lo));
      meas(1'b1, hi, lo);
      chk("irq width", 16'(dv), 16'(hi));
      chk("irq interval", 16'((n + 1) * dv), 16'(hi + lo));
      stop(IPTMR_MD_INTERVAL);
    end
    oen = 1'b0;
    sel = 3'h0;
    n = 8'(1 + {$random(seed)} % 12);
    lev = 1'($random(seed));
    start(IPTMR_MD_INTERVAL);
    for (int j = 0; j < 3; j++)
    begin
      wait_for(1'b1, 1'b1, c);
      tick(1);
      chk("out disabled", 16'(lev), 16'(t_out));
    end
    stop(IPTMR_MD_INTERVAL);
    oen = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      sel = 3'({$random(seed)} % 2);
      dv = 1 << sel;
      n = 8'(2 + {$random(seed)} % 14);
      m = 8'({$random(seed)} % n);
      m2 = 8'({$random(seed)} % n);
      lev = 1'($random(seed));
      start(IPTMR_MD_PWM);
      chk("pwm idle", 16'h0000, 16'(sig(1'b0)));
      wait_for(1'b1, 1'b1, c);
      if (sel == 0)
        chk("pwm first", 16'(n + 2), 16'(c + 1));
      chk("act at irq", 16'h0001, 16'(sig(1'b0)));
      chk("pin drive", 16'(t_out), 16'(pin_o));
      meas(1'b0, hi, lo);
      chk("pwm high", 16'((m + 1) * dv), 16'(hi));
      chk("pwm low", 16'((n - m) * dv), 16'(lo));
      meas(1'b1, hi, lo);
      chk("pwm cycle", 16'((n + 1) * dv), 16'(hi + lo));
      bus(1'b1, `IPTMR_ADDR_DUTY, m2);
      rdchk("duty held", `IPTMR_ADDR_DUTY, m);
      meas(1'b0, hi, lo);
      meas(1'b0, hi, lo);
      meas(1'b0, hi, lo);
      chk("new high", 16'((m2 + 1) * dv), 16'(hi));
      rdchk("duty moved", `IPTMR_ADDR_DUTY, m2);
      stop(IPTMR_MD_PWM);
    end
    summarize();
  end
endmodule
